// ---- rtl/host_port_device.sv ----
`timescale 1ns/1ps
`include "host_port_consts.svh"

module host_port_device (
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    host_port_if.device bus,
    input wire host_port_pkg::base_match_t BASE_ADDR_I,
    input wire logic NO_WAIT_I,
    input wire logic [1:0] INT_SEL_I,
    input wire logic IRQ_I,
    input wire host_port_pkg::data_word_t REG_RDATA_I,
    output host_port_pkg::word_addr_t REG_ADDR_O,
    output logic [1:0] REG_BE_O,
    output logic REG_RD_O,
    output logic REG_WR_O,
    output host_port_pkg::data_word_t REG_WDATA_O,
    output logic RESET_O
);
    import host_port_pkg::*;

    function automatic logic base_hit(input word_addr_t addr, input logic qual_n, input base_match_t base);
        base_hit = !qual_n && (addr[15:4] == base);
    endfunction

    // Address latch, transparent while the strobe is low
    word_addr_t addr_lat_reg, addr_lat_next;
    logic qual_lat_reg, qual_lat_next;
    logic [1:0] be_lat_reg, be_lat_next;
    word_addr_t addr_eff;
    logic qual_eff;
    logic [1:0] be_eff;

    always_comb begin
        addr_lat_next = addr_lat_reg;
        qual_lat_next = qual_lat_reg;
        be_lat_next = be_lat_reg;
        if (!bus.address_strobe_n) begin
            addr_lat_next = bus.address;
            qual_lat_next = bus.address_qualifier_n;
            be_lat_next = bus.byte_enable_n;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            addr_lat_reg <= '0;
            qual_lat_reg <= 1'b1;
            be_lat_reg <= 2'h3;
        end else begin
            addr_lat_reg <= addr_lat_next;
            qual_lat_reg <= qual_lat_next;
            be_lat_reg <= be_lat_next;
        end
    end

    // Held after the strobe rises, straight through while it is low
    assign addr_eff = bus.address_strobe_n ? addr_lat_reg : bus.address;
    assign qual_eff = bus.address_strobe_n ? qual_lat_reg : bus.address_qualifier_n;
    assign be_eff = bus.address_strobe_n ? be_lat_reg : bus.byte_enable_n;

    logic selected;
    assign selected = base_hit(addr_eff, qual_eff, BASE_ADDR_I);

    // Local select bypasses the latch entirely
    assign bus.local_device_sel_n = !base_hit(bus.address, bus.address_qualifier_n, BASE_ADDR_I);

    // Glitch filter on the reset pin
    logic [3:0] rst_cnt_reg, rst_cnt_next;
    logic rst_out_reg, rst_out_next;

    always_comb begin
        rst_cnt_next = 4'h0;
        rst_out_next = 1'b0;
        if (bus.reset_pin) begin
            rst_cnt_next = (rst_cnt_reg == 4'(`RESET_MIN_CYC)) ? rst_cnt_reg : rst_cnt_reg + 4'h1;
            rst_out_next = (rst_cnt_next == 4'(`RESET_MIN_CYC));
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            rst_cnt_reg <= 4'h0;
            rst_out_reg <= 1'b0;
        end else begin
            rst_cnt_reg <= rst_cnt_next;
            rst_out_reg <= rst_out_next;
        end
    end

    assign RESET_O = rst_out_reg;

    logic port_clear;
    assign port_clear = !RST_B_I || rst_out_reg;

    // Strobe tracking, read data and write capture
    logic rd_prev_reg, rd_prev_next;
    logic wr_prev_reg, wr_prev_next;
    logic rd_fall, wr_fall, wr_rise;
    logic rd_active_reg, rd_active_next;
    data_word_t rdata_reg, rdata_next;
    data_word_t wdata_reg, wdata_next;
    word_addr_t reg_addr_reg, reg_addr_next;
    logic [1:0] reg_be_reg, reg_be_next;
    logic wr_sel_reg, wr_sel_next;
    logic rd_pulse_reg, rd_pulse_next;
    logic wr_pulse_reg, wr_pulse_next;

    assign rd_fall = rd_prev_reg && !bus.read_strobe_n;
    assign wr_fall = wr_prev_reg && !bus.write_strobe_n;
    assign wr_rise = !wr_prev_reg && bus.write_strobe_n;

    always_comb begin
        rd_prev_next = bus.read_strobe_n;
        wr_prev_next = bus.write_strobe_n;
        rd_active_next = rd_active_reg && !bus.read_strobe_n;
        rdata_next = rdata_reg;
        wdata_next = wdata_reg;
        reg_addr_next = reg_addr_reg;
        reg_be_next = reg_be_reg;
        wr_sel_next = wr_sel_reg;
        rd_pulse_next = 1'b0;
        wr_pulse_next = 1'b0;
        if (rd_fall && selected) begin
            rd_active_next = 1'b1;
            rd_pulse_next = 1'b1;
            reg_addr_next = addr_eff;
            reg_be_next = ~be_eff;
            rdata_next = REG_RDATA_I;
        end
        if (wr_fall) begin
            wr_sel_next = selected;
            reg_addr_next = addr_eff;
            reg_be_next = ~be_eff;
        end
        // Data is tracked while the write strobe is low and committed at its rise
        if (!bus.write_strobe_n && wr_sel_reg) begin
            wdata_next = bus.data;
        end
        if (wr_rise && wr_sel_reg) begin
            wr_pulse_next = 1'b1;
            wr_sel_next = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (port_clear) begin
            rd_prev_reg <= 1'b1;
            wr_prev_reg <= 1'b1;
            rd_active_reg <= 1'b0;
            rdata_reg <= '0;
            wdata_reg <= '0;
            reg_addr_reg <= '0;
            reg_be_reg <= 2'h0;
            wr_sel_reg <= 1'b0;
            rd_pulse_reg <= 1'b0;
            wr_pulse_reg <= 1'b0;
        end else begin
            rd_prev_reg <= rd_prev_next;
            wr_prev_reg <= wr_prev_next;
            rd_active_reg <= rd_active_next;
            rdata_reg <= rdata_next;
            wdata_reg <= wdata_next;
            reg_addr_reg <= reg_addr_next;
            reg_be_reg <= reg_be_next;
            wr_sel_reg <= wr_sel_next;
            rd_pulse_reg <= rd_pulse_next;
            wr_pulse_reg <= wr_pulse_next;
        end
    end

    // Read data is driven only while the read strobe of a selected cycle is low
    assign bus.dev_data = rdata_reg;
    assign bus.dev_data_oe = rd_active_reg && !bus.read_strobe_n;
    assign REG_ADDR_O = reg_addr_reg;
    assign REG_BE_O = reg_be_reg;
    assign REG_RD_O = rd_pulse_reg;
    assign REG_WR_O = wr_pulse_reg;
    assign REG_WDATA_O = wdata_reg;

    // Ready stretch, timed from the device clock
    logic [3:0] rdy_cnt_reg, rdy_cnt_next;

    always_comb begin
        rdy_cnt_next = rdy_cnt_reg;
        if (rdy_cnt_reg != 4'h0) begin
            rdy_cnt_next = rdy_cnt_reg - 4'h1;
        end
        if ((rd_fall || wr_fall) && selected && !NO_WAIT_I) begin
            rdy_cnt_next = 4'(`READY_HOLD_CYC);
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (port_clear) begin
            rdy_cnt_reg <= 4'h0;
        end else begin
            rdy_cnt_reg <= rdy_cnt_next;
        end
    end

    // Open drain: only ever pulls low, release is the completion edge
    assign bus.async_ready_od = 1'b0;
    assign bus.async_ready_oe = (rdy_cnt_reg != 4'h0);

    // Interrupt routing
    logic irq_reg, irq_next;
    logic irq_oe_reg, irq_oe_next;

    always_comb begin
        irq_oe_next = (INT_SEL_I == `IRQ_ROUTE_PIN);
        irq_next = irq_oe_next && IRQ_I;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (port_clear) begin
            irq_reg <= 1'b0;
            irq_oe_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
            irq_oe_reg <= irq_oe_next;
        end
    end

    assign bus.irq_out = irq_reg;
    assign bus.irq_out_oe = irq_oe_reg;
endmodule // host_port_device

// ---- rtl/host_port_consts.svh ----
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH

// System clock period, in nanoseconds
`define CLK_PERIOD_NS 50

// Least width of a reset pulse that is taken as real
`define RESET_MIN_NS 100
`define RESET_MIN_CYC ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Window in which the ready line is held low
`define READY_MIN_NS 100
`define READY_MAX_NS 150
`define READY_HOLD_CYC ((`READY_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Host strobe width before it looks at the ready line
`define HOST_STROBE_MIN_CYC 2
// Host reset pulse width, one cycle over the least width
`define HOST_RESET_CYC (`RESET_MIN_CYC + 1)

// Routing code that sends the interrupt to the interrupt pin
`define IRQ_ROUTE_PIN 2'h0

// Level of an undriven data bus, held by the weak pull-ups
`define DATA_PULLUP 16'hFFFF

`endif

// ---- rtl/host_port_pkg.sv ----
package host_port_pkg;
    typedef logic [15:1] word_addr_t;
    typedef logic [15:0] data_word_t;
    typedef logic [15:4] base_match_t;

    typedef enum logic [2:0] {
        HOST_IDLE,
        HOST_ADDR,
        HOST_LATCH,
        HOST_STROBE,
        HOST_WAIT,
        HOST_RESET
    } host_state_t;
endpackage

// ---- rtl/host_port_if.sv ----
`timescale 1ns/1ps
`include "host_port_consts.svh"

interface host_port_if;
    logic [15:1] address;
    logic address_qualifier_n;
    logic [1:0] byte_enable_n;
    logic address_strobe_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic reset_pin;
    logic [15:0] host_data;
    logic host_data_oe;
    logic [15:0] dev_data;
    logic dev_data_oe;
    logic [15:0] data;
    logic async_ready_od;
    logic async_ready_oe;
    logic ready;
    logic local_device_sel_n;
    logic irq_out;
    logic irq_out_oe;

    // Wire levels: data bus pulled up, ready open drain pulled up, irq low when not driven
    assign data = dev_data_oe ? dev_data : (host_data_oe ? host_data : `DATA_PULLUP);
    assign ready = async_ready_oe ? async_ready_od : 1'b1;

    modport device (
        input address, address_qualifier_n, byte_enable_n, address_strobe_n,
        input read_strobe_n, write_strobe_n, reset_pin, data,
        output dev_data, dev_data_oe, async_ready_od, async_ready_oe,
        output local_device_sel_n, irq_out, irq_out_oe
    );

    modport host (
        output address, address_qualifier_n, byte_enable_n, address_strobe_n,
        output read_strobe_n, write_strobe_n, reset_pin, host_data, host_data_oe,
        input data, ready, local_device_sel_n, irq_out, irq_out_oe
    );
endinterface

// ---- rtl/host_port_host.sv ----
`timescale 1ns/1ps
`include "host_port_consts.svh"

module host_port_host #(
    parameter bit USE_ADDR_STROBE = 1'b1
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    host_port_if.host bus,
    input wire logic CMD_VALID_I,
    input wire logic CMD_WRITE_I,
    input wire host_port_pkg::word_addr_t CMD_ADDR_I,
    input wire logic [1:0] CMD_BE_N_I,
    input wire host_port_pkg::data_word_t CMD_WDATA_I,
    input wire logic RESET_REQ_I,
    output logic CMD_READY_O,
    output logic RSP_VALID_O,
    output host_port_pkg::data_word_t RSP_RDATA_O
);
    import host_port_pkg::*;

    host_state_t state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic write_reg, write_next;
    word_addr_t addr_reg, addr_next;
    logic [1:0] be_n_reg, be_n_next;
    data_word_t wdata_reg, wdata_next;
    data_word_t rdata_reg, rdata_next;
    logic rsp_reg, rsp_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        write_next = write_reg;
        addr_next = addr_reg;
        be_n_next = be_n_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        rsp_next = 1'b0;
        case (state_reg)
            HOST_IDLE: begin
                if (RESET_REQ_I) begin
                    state_next = HOST_RESET;
                    cnt_next = 4'(`HOST_RESET_CYC);
                end else if (CMD_VALID_I) begin
                    write_next = CMD_WRITE_I;
                    addr_next = CMD_ADDR_I;
                    be_n_next = CMD_BE_N_I;
                    wdata_next = CMD_WDATA_I;
                    state_next = USE_ADDR_STROBE ? HOST_ADDR : HOST_STROBE;
                    cnt_next = 4'(`HOST_STROBE_MIN_CYC);
                end
            end
            HOST_ADDR: state_next = HOST_LATCH;
            HOST_LATCH: state_next = HOST_STROBE;
            HOST_STROBE: begin
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h1) begin
                    state_next = HOST_WAIT;
                end
            end
            HOST_WAIT: begin
                if (bus.ready) begin
                    rdata_next = bus.data;
                    rsp_next = 1'b1;
                    state_next = HOST_IDLE;
                end
            end
            HOST_RESET: begin
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h1) begin
                    state_next = HOST_IDLE;
                end
            end
            default: state_next = HOST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            state_reg <= HOST_IDLE;
            cnt_reg <= 4'h0;
            write_reg <= 1'b0;
            addr_reg <= '0;
            be_n_reg <= 2'h3;
            wdata_reg <= '0;
            rdata_reg <= '0;
            rsp_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            write_reg <= write_next;
            addr_reg <= addr_next;
            be_n_reg <= be_n_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            rsp_reg <= rsp_next;
        end
    end

    logic in_cycle;
    logic strobing;
    assign in_cycle = (state_reg != HOST_IDLE) && (state_reg != HOST_RESET);
    assign strobing = (state_reg == HOST_STROBE) || (state_reg == HOST_WAIT);

    assign bus.address = addr_reg;
    assign bus.address_qualifier_n = !in_cycle;
    assign bus.byte_enable_n = in_cycle ? be_n_reg : 2'h3;
    // Strobe pulses low in the address phase; held low for transparent use
    assign bus.address_strobe_n = USE_ADDR_STROBE ? (state_reg != HOST_ADDR) : 1'b0;
    assign bus.read_strobe_n = !(strobing && !write_reg);
    assign bus.write_strobe_n = !(strobing && write_reg);
    assign bus.host_data = wdata_reg;
    assign bus.host_data_oe = in_cycle && write_reg;
    assign bus.reset_pin = (state_reg == HOST_RESET);

    assign CMD_READY_O = (state_reg == HOST_IDLE) && !RESET_REQ_I;
    assign RSP_VALID_O = rsp_reg;
    assign RSP_RDATA_O = rdata_reg;
endmodule // host_port_host

// ---- verification/host_port_properties.sv ----
`timescale 1ns/1ps
`include "host_port_consts.svh"

module host_port_properties (
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    input wire logic [15:1] address,
    input wire logic address_qualifier_n,
    input wire logic address_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic async_ready_od,
    input wire logic async_ready_oe,
    input wire logic dev_data_oe,
    input wire logic local_device_sel_n,
    input wire logic irq_out_oe,
    input wire host_port_pkg::base_match_t BASE_ADDR_I,
    input wire logic NO_WAIT_I,
    input wire logic [1:0] INT_SEL_I,
    input wire logic reset_pin,
    input wire logic reset_filtered
);
    import host_port_pkg::*;

    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_B_I);

    sel_decode_a: assert property (
        local_device_sel_n == !(!address_qualifier_n && address[15:4] == BASE_ADDR_I))
        else $error("local select differs from address decode");
    ready_width_a: assert property ($rose(async_ready_oe) |=> async_ready_oe ##1 !async_ready_oe)
        else $error("ready not held for two cycles");
    no_wait_a: assert property (NO_WAIT_I |-> !async_ready_oe)
        else $error("ready pulled while no-wait is set");
    ready_start_a: assert property (
        ($fell(read_strobe_n) || $fell(write_strobe_n)) && !local_device_sel_n && !NO_WAIT_I |=> async_ready_oe)
        else $error("ready not pulled after selected strobe");
    ready_drive_a: assert property (async_ready_oe |-> !async_ready_od)
        else $error("ready driven high");
    sel_gate_a: assert property (
        local_device_sel_n && $past(local_device_sel_n) |-> !dev_data_oe && !async_ready_oe)
        else $error("device answered while not selected");
    rd_drive_a: assert property (dev_data_oe |-> !$past(read_strobe_n))
        else $error("data driven without read strobe");
    irq_route_a: assert property (irq_out_oe |-> $past(INT_SEL_I) == `IRQ_ROUTE_PIN)
        else $error("interrupt pin driven while not routed");
    latch_order_a: assert property (
        $fell(read_strobe_n) || $fell(write_strobe_n) |-> address_strobe_n && $past(address_strobe_n))
        else $error("strobe fell before address latched");
    reset_filter_a: assert property (reset_filtered |-> $past(reset_pin) && $past(reset_pin, 2))
        else $error("reset passed before the least width");
    reset_take_a: assert property (reset_pin && $past(reset_pin) && $past(reset_pin, 2) |-> reset_filtered)
        else $error("held reset not taken");

    cover property ($fell(read_strobe_n) && !local_device_sel_n);
    cover property ($fell(write_strobe_n) && !local_device_sel_n);
    cover property (irq_out_oe);
    cover property (reset_filtered);
endmodule // host_port_properties

// ---- verification/tb_async_host_bus_interface.sv ----
`timescale 1ns/1ps
`include "host_port_consts.svh"

`define CHECK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin failures++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

module tb_async_host_bus_interface;
    import host_port_pkg::*;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid = 1'b0, cmd_write = 1'b0, reset_req = 1'b0, no_wait = 1'b0, irq = 1'b0;
    word_addr_t cmd_addr = '0;
    logic [1:0] cmd_be_n = 2'h0, int_sel = 2'h1;
    data_word_t cmd_wdata = '0, reg_rdata = '0, rsp_rdata, reg_wdata;
    base_match_t base_addr = 12'h123;
    logic cmd_ready, rsp_valid, reg_rd, reg_wr, reset_out;
    word_addr_t reg_addr;
    data_word_t rsp_rdata_t, reg_wdata_t;
    word_addr_t reg_addr_t;
    logic [1:0] reg_be;
    int failures = 0, total_checks = 0, wr_count = 0, rd_count = 0, wait_cycles = 0;
    logic reset_seen = 1'b0;

    initial forever #25 clk = ~clk;

    host_port_if bus ();

    host_port_host host_port_host_i (.SYS_CLK_I(clk), .RST_B_I(rst_b), .bus(bus), .CMD_VALID_I(cmd_valid),
        .CMD_WRITE_I(cmd_write), .CMD_ADDR_I(cmd_addr), .CMD_BE_N_I(cmd_be_n), .CMD_WDATA_I(cmd_wdata),
        .RESET_REQ_I(reset_req), .CMD_READY_O(cmd_ready), .RSP_VALID_O(rsp_valid), .RSP_RDATA_O(rsp_rdata));

    host_port_device host_port_device_i (.SYS_CLK_I(clk), .RST_B_I(rst_b), .bus(bus), .BASE_ADDR_I(base_addr),
        .NO_WAIT_I(no_wait), .INT_SEL_I(int_sel), .IRQ_I(irq), .REG_RDATA_I(reg_rdata), .REG_ADDR_O(reg_addr),
        .REG_BE_O(reg_be), .REG_RD_O(reg_rd), .REG_WR_O(reg_wr), .REG_WDATA_O(reg_wdata), .RESET_O(reset_out));

    // Second pair with the address strobe held low, so the device latch stays transparent
    host_port_if bus_t ();

    host_port_host #(.USE_ADDR_STROBE(1'b0)) host_port_host_t_i (.SYS_CLK_I(clk), .RST_B_I(rst_b), .bus(bus_t),
        .CMD_VALID_I(cmd_valid), .CMD_WRITE_I(cmd_write), .CMD_ADDR_I(cmd_addr), .CMD_BE_N_I(cmd_be_n),
        .CMD_WDATA_I(cmd_wdata), .RESET_REQ_I(reset_req), .CMD_READY_O(), .RSP_VALID_O(),
        .RSP_RDATA_O(rsp_rdata_t));

    host_port_device host_port_device_t_i (.SYS_CLK_I(clk), .RST_B_I(rst_b), .bus(bus_t), .BASE_ADDR_I(base_addr),
        .NO_WAIT_I(no_wait), .INT_SEL_I(int_sel), .IRQ_I(irq), .REG_RDATA_I(reg_rdata), .REG_ADDR_O(reg_addr_t),
        .REG_BE_O(), .REG_RD_O(), .REG_WR_O(), .REG_WDATA_O(reg_wdata_t), .RESET_O());

    host_port_properties host_port_properties_i (.SYS_CLK_I(clk), .RST_B_I(rst_b), .address(bus.address),
        .address_qualifier_n(bus.address_qualifier_n), .address_strobe_n(bus.address_strobe_n),
        .read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
        .async_ready_od(bus.async_ready_od), .async_ready_oe(bus.async_ready_oe), .dev_data_oe(bus.dev_data_oe),
        .local_device_sel_n(bus.local_device_sel_n), .irq_out_oe(bus.irq_out_oe), .BASE_ADDR_I(base_addr),
        .NO_WAIT_I(no_wait), .INT_SEL_I(int_sel), .reset_pin(bus.reset_pin), .reset_filtered(reset_out));

    // Counts device-side events so each access can be judged afterwards
    always @(posedge clk) begin
        if (reg_wr === 1'b1) wr_count <= wr_count + 1;
        if (reg_rd === 1'b1) rd_count <= rd_count + 1;
        if (bus.ready === 1'b0) wait_cycles <= wait_cycles + 1;
        if (reset_out === 1'b1) reset_seen <= 1'b1;
    end

    task automatic stop_test();
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic access(input logic wr, input word_addr_t a, input logic [1:0] be_n, input data_word_t wd);
        int n;
        @(posedge clk);
        cmd_write <= wr;
        cmd_addr <= a;
        cmd_be_n <= be_n;
        cmd_wdata <= wd;
        cmd_valid <= 1'b1;
        n = 0;
        do begin @(negedge clk); n++; end while (cmd_ready !== 1'b1 && n < 20);
        @(posedge clk);
        cmd_valid <= 1'b0;
        do begin @(negedge clk); n++; end while (rsp_valid !== 1'b1 && n < 40);
        if (n >= 40) begin
            failures++;
            stop_test();
        end
    endtask

    task automatic do_write(input word_addr_t a, input logic [1:0] be_n, input data_word_t d, input int sel);
        int exp_wr;
        exp_wr = wr_count + sel;
        access(1'b1, a, be_n, d);
        repeat (2) @(negedge clk);
        `CHECK("write pulses", exp_wr, wr_count)
        if (sel == 1) begin
            `CHECK("write address", a, reg_addr)
            `CHECK("byte lanes", ~be_n, reg_be)
            `CHECK("write data", d, reg_wdata)
            `CHECK("transparent write address", a, reg_addr_t)
            `CHECK("transparent write data", d, reg_wdata_t)
        end
    endtask

    task automatic do_read(input word_addr_t a, input data_word_t d, input data_word_t exp, input int waits);
        int exp_rd, exp_wait;
        exp_rd = rd_count + (exp === d);
        exp_wait = wait_cycles + waits;
        @(posedge clk);
        reg_rdata <= d;
        access(1'b0, a, 2'h0, 16'h0000);
        `CHECK("read data", exp, rsp_rdata)
        `CHECK("transparent read data", exp, rsp_rdata_t)
        if (exp === d) `CHECK("read address", a, reg_addr)
        repeat (2) @(negedge clk);
        `CHECK("read pulses", exp_rd, rd_count)
        `CHECK("ready low cycles", exp_wait, wait_cycles)
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        do_write({12'h123, 3'h7}, 2'b00, 16'hA5C3, 1);
        do_write({12'h123, 3'h0}, 2'b01, 16'h5A3C, 1);
        do_write({12'h123, 3'h4}, 2'b10, 16'hFFFF, 1);
        do_read({12'h123, 3'h1}, 16'h1234, 16'h1234, 2);
        do_read({12'h123, 3'h2}, 16'hBEEF, 16'hBEEF, 2);
        do_write({12'h124, 3'h0}, 2'b00, 16'h0001, 0);
        do_read({12'h124, 3'h0}, 16'h1234, `DATA_PULLUP, 0);
        @(posedge clk);
        no_wait <= 1'b1;
        do_read({12'h123, 3'h3}, 16'h0F0F, 16'h0F0F, 0);
        @(posedge clk);
        no_wait <= 1'b0;
        irq <= 1'b1;
        repeat (3) @(negedge clk);
        `CHECK("irq not routed", 1'b0, bus.irq_out_oe)
        `CHECK("irq pin quiet", 1'b0, bus.irq_out)
        @(posedge clk);
        int_sel <= `IRQ_ROUTE_PIN;
        repeat (3) @(negedge clk);
        `CHECK("irq routed", 1'b1, bus.irq_out_oe)
        `CHECK("irq level", 1'b1, bus.irq_out)
        @(posedge clk);
        irq <= 1'b0;
        repeat (3) @(negedge clk);
        `CHECK("irq follows", 1'b0, bus.irq_out)
        @(posedge clk);
        reset_req <= 1'b1;
        @(posedge clk);
        reset_req <= 1'b0;
        repeat (10) @(negedge clk);
        `CHECK("reset filtered", 1'b1, reset_seen)
        `CHECK("reset released", 1'b0, reset_out)
        do_write({12'h123, 3'h5}, 2'b00, 16'h3C3C, 1);
        stop_test();
    end
endmodule // tb_async_host_bus_interface
